// ==== src/atqpd_avg.sv ====
// Moving average of the load count over a selectable number of half-cycles
`timescale 1ns/1ps
`default_nettype none
module atqpd_avg
  import atqpd_pkg::*;
(
  input wire logic pclk, // Register clock
  input wire logic presetn, // Async reset, low active
  atqpd_avg_if.avg bus // Sample in, average out
);
  logic [10:0] hist [8];
  logic [10:0] next_hist [8];
  logic [10:0] next_average;
  logic [13:0] sum;
  logic [1:0] shift;
  logic [3:0] depth;

  // Window code to depth; other codes mean no averaging
  always_comb begin
    unique case (bus.window)
      WIN_TWO: begin shift = 2'd1; depth = 4'd2; end
      WIN_FOUR: begin shift = 2'd2; depth = 4'd4; end
      WIN_EIGHT: begin shift = 2'd3; depth = 4'd8; end
      default: begin shift = 2'd0; depth = 4'd1; end
    endcase
  end

  // History shift and windowed sum
  always_comb begin
    next_hist = hist;
    next_average = bus.average;
    sum = 14'h0000;
    if (bus.sample_valid) begin
      next_hist[0] = bus.sample;
      for (int i = 1; i < 8; i++) begin
        next_hist[i] = hist[i-1];
      end
      for (int i = 0; i < 8; i++) begin
        if (4'(i) < depth) begin
          sum = sum + 14'(next_hist[i]);
        end
      end
      next_average = 11'(sum >> shift);
    end
  end

  // History and output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        hist[i] <= 11'h000;
      end
      bus.average <= 11'h000;
    end else begin
      hist <= next_hist;
      bus.average <= next_average;
    end
  end
endmodule : atqpd_avg
`default_nettype wire

// ==== src/atqpd_avg_if.sv ====
// Interface: load samples into the averager and the averaged count back
`timescale 1ns/1ps
`default_nettype none
interface atqpd_avg_if;
  logic [10:0] sample;
  logic sample_valid;
  logic [2:0] window;
  logic [10:0] average;
  modport src (output sample, output sample_valid, output window, input average);
  modport avg (input sample, input sample_valid, input window, output average);
endinterface : atqpd_avg_if
`default_nettype wire

// ==== src/atqpd_pkg.sv ====
// Package: register map, field layout and reset values of the torque loop block
package atqpd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] LEARN_HI_IDX = 8'h22;
  localparam logic [7:0] LEARN_LO_IDX = 8'h23;
  localparam logic [7:0] BAND_UP_IDX = 8'h24;
  localparam logic [7:0] BAND_LO_IDX = 8'h25;
  localparam logic [7:0] PGAIN_IDX = 8'h26;
  localparam logic [7:0] DGAIN_IDX = 8'h27;
  localparam logic [7:0] CTRL_IDX = 8'h28;
  localparam logic [7:0] LOAD_LO_IDX = 8'h30;
  localparam logic [7:0] LOAD_HI_IDX = 8'h31;
  localparam logic [7:0] FLOOR_IDX = 8'h32;
  localparam logic [7:0] CEIL_IDX = 8'h33;
  localparam logic [7:0] STEP_IDX = 8'h34;
  localparam logic [7:0] APPLIED_IDX = 8'h35;
  // Reset values
  localparam logic [7:0] LEARN_HI_RST = 8'h20;
  localparam logic [7:0] CTRL_RST = 8'h08;
  localparam logic [7:0] FLOOR_RST = 8'h0a;
  localparam logic [7:0] CEIL_RST = 8'hff;
  // Field positions
  localparam int START_LSB = 3;
  localparam int EN_BIT = 7;
  localparam int TRIG_BIT = 6;
  localparam int HOLD_LSB = 3;
  localparam int WIN_LSB = 0;
  localparam int LEARN_MULT_SHIFT = 3;
  localparam int BAND_SHIFT = 3;
  localparam int CORR_SHIFT = 4;
  // Averaging window codes
  localparam logic [2:0] WIN_TWO = 3'h2;
  localparam logic [2:0] WIN_FOUR = 3'h4;
  localparam logic [2:0] WIN_EIGHT = 3'h7;
  // Learning increments by step code
  localparam logic [8:0] STEP_00 = 9'h080;
  localparam logic [8:0] STEP_01 = 9'h010;
  localparam logic [8:0] STEP_10 = 9'h020;
  localparam logic [8:0] STEP_11 = 9'h040;
  localparam logic [2:0] HOLD_MIN = 3'h1;
  // Learning sequence states, Gray along idle, initial, final
  typedef enum logic [1:0] {
    ATQPD_IDLE = 2'b00,
    ATQPD_INIT = 2'b01,
    ATQPD_FINAL = 2'b11
  } atqpd_learn_t;
endpackage : atqpd_pkg

// ==== src/atqpd_top.sv ====
// Torque learning and PD current loop with its APB register bank
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module atqpd_top
  import atqpd_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int LEARN_HALF_CYCLES = 8
) (
  input wire logic pclk, // APB clock, 40 MHz
  input wire logic presetn, // Async reset, low active
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic half_cycle, // Electrical half-cycle boundary pulse
  input wire logic [10:0] load_sample, // Raw load measure per half-cycle
  output logic [7:0] coil_current, // Current level to the bridge
  output logic learning // Learning routine active
);
  // Elaboration checks on parameters the logic cannot serve
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("ADDR_W too small");
  end
  if (LEARN_HALF_CYCLES < 1 || LEARN_HALF_CYCLES > 255) begin : g_bad_learn
    $error("LEARN_HALF_CYCLES out of range");
  end

  localparam logic [7:0] LEARN_HC = 8'(LEARN_HALF_CYCLES);

  // Saturate a 9-bit level to 8 bits
  function automatic logic [7:0] sat8(input logic [8:0] v);
    return v[8] ? 8'hff : v[7:0];
  endfunction : sat8

  // Absolute difference of two 8-bit values
  function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : absdiff

  // Register state
  logic [7:0] learn_hi, learn_lo, band_upper_limit, band_lower_limit;
  logic [7:0] proportional_gain, dgain_reg, ctrl, floor_reg, ceil_reg;
  logic [1:0] learn_level_increment;
  logic [7:0] next_learn_hi, next_learn_lo, next_band_up, next_band_lo;
  logic [7:0] next_pgain, next_dgain, next_ctrl, next_floor, next_ceil;
  logic [1:0] next_step;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [7:0] idx;
  logic wr_en, setup_phase, mapped;
  logic learn_done;
  logic [10:0] learn_capture;

  atqpd_avg_if avg_bus ();
  logic [10:0] load_torque_count;

  logic torque_adapt_enable, learn_trigger;
  logic [2:0] update_hold_delay, load_average_window, hold_eff;
  logic [3:0] derivative_gain;
  assign torque_adapt_enable = ctrl[EN_BIT];
  assign learn_trigger = ctrl[TRIG_BIT];
  assign update_hold_delay = ctrl[HOLD_LSB +: 3];
  assign load_average_window = ctrl[WIN_LSB +: 3];
  assign derivative_gain = dgain_reg[3:0];
  assign hold_eff = (update_hold_delay < HOLD_MIN) ? HOLD_MIN : update_hold_delay;

  // APB decode; no wait states, pready is tied high and read data comes from a flop
  assign idx = 8'(paddr >> 2);
  assign setup_phase = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign pready = 1'b1;
  always_comb begin
    if (idx == LEARN_HI_IDX) mapped = 1'b1;
    else if (idx == LEARN_LO_IDX) mapped = 1'b1;
    else if (idx == BAND_UP_IDX) mapped = 1'b1;
    else if (idx == BAND_LO_IDX) mapped = 1'b1;
    else if (idx == PGAIN_IDX) mapped = 1'b1;
    else if (idx == DGAIN_IDX) mapped = 1'b1;
    else if (idx == CTRL_IDX) mapped = 1'b1;
    else if (idx == LOAD_LO_IDX) mapped = 1'b1;
    else if (idx == LOAD_HI_IDX) mapped = 1'b1;
    else if (idx == FLOOR_IDX) mapped = 1'b1;
    else if (idx == CEIL_IDX) mapped = 1'b1;
    else if (idx == STEP_IDX) mapped = 1'b1;
    else if (idx == APPLIED_IDX) mapped = 1'b1;
    else mapped = 1'b0;
    mapped = mapped && (paddr[1:0] == 2'b00);
  end

  // Read mux, latched in the setup cycle
  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (setup_phase) begin
      next_pslverr = !mapped;
      next_prdata = 32'h0000_0000;
      if (idx == LEARN_HI_IDX) next_prdata[7:0] = learn_hi;
      else if (idx == LEARN_LO_IDX) next_prdata[7:0] = learn_lo;
      else if (idx == BAND_UP_IDX) next_prdata[7:0] = band_upper_limit;
      else if (idx == BAND_LO_IDX) next_prdata[7:0] = band_lower_limit;
      else if (idx == PGAIN_IDX) next_prdata[7:0] = proportional_gain;
      else if (idx == DGAIN_IDX) next_prdata[7:0] = dgain_reg;
      else if (idx == CTRL_IDX) next_prdata[7:0] = ctrl;
      else if (idx == LOAD_LO_IDX) next_prdata[7:0] = load_torque_count[7:0];
      else if (idx == LOAD_HI_IDX) next_prdata[2:0] = load_torque_count[10:8];
      else if (idx == FLOOR_IDX) next_prdata[7:0] = floor_reg;
      else if (idx == CEIL_IDX) next_prdata[7:0] = ceil_reg;
      else if (idx == STEP_IDX) next_prdata[1:0] = learn_level_increment;
      else if (idx == APPLIED_IDX) next_prdata[7:0] = coil_current;
    end
  end

  // Register writes, trigger self-clear and learned value capture
  always_comb begin
    next_learn_hi = learn_hi;
    next_learn_lo = learn_lo;
    next_band_up = band_upper_limit;
    next_band_lo = band_lower_limit;
    next_pgain = proportional_gain;
    next_dgain = dgain_reg;
    next_ctrl = ctrl;
    next_floor = floor_reg;
    next_ceil = ceil_reg;
    next_step = learn_level_increment;
    if (learn_done) begin
      next_ctrl[TRIG_BIT] = 1'b0;
      next_learn_hi[2:0] = learn_capture[10:8];
      next_learn_lo = learn_capture[7:0];
    end
    if (wr_en) begin
      if (idx == LEARN_HI_IDX) next_learn_hi = pwdata[7:0];
      else if (idx == LEARN_LO_IDX) next_learn_lo = pwdata[7:0];
      else if (idx == BAND_UP_IDX) next_band_up = pwdata[7:0];
      else if (idx == BAND_LO_IDX) next_band_lo = pwdata[7:0];
      else if (idx == PGAIN_IDX) next_pgain = pwdata[7:0];
      else if (idx == DGAIN_IDX) next_dgain = pwdata[7:0];
      else if (idx == CTRL_IDX) begin
        next_ctrl = pwdata[7:0];
        // A set arriving with completion wins
        if (learn_trigger && !pwdata[TRIG_BIT] && !learn_done) next_ctrl[TRIG_BIT] = 1'b1;
      end
      else if (idx == FLOOR_IDX) next_floor = pwdata[7:0];
      else if (idx == CEIL_IDX) next_ceil = pwdata[7:0];
      else if (idx == STEP_IDX) next_step = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      learn_hi <= LEARN_HI_RST;
      learn_lo <= 8'h00;
      band_upper_limit <= 8'h00;
      band_lower_limit <= 8'h00;
      proportional_gain <= 8'h00;
      dgain_reg <= 8'h00;
      ctrl <= CTRL_RST;
      floor_reg <= FLOOR_RST;
      ceil_reg <= CEIL_RST;
      learn_level_increment <= 2'b00;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      learn_hi <= next_learn_hi;
      learn_lo <= next_learn_lo;
      band_upper_limit <= next_band_up;
      band_lower_limit <= next_band_lo;
      proportional_gain <= next_pgain;
      dgain_reg <= next_dgain;
      ctrl <= next_ctrl;
      floor_reg <= next_floor;
      ceil_reg <= next_ceil;
      learn_level_increment <= next_step;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Load averaging
  assign avg_bus.sample = load_sample;
  assign avg_bus.sample_valid = half_cycle;
  assign avg_bus.window = load_average_window;
  assign load_torque_count = avg_bus.average;
  atqpd_avg u_avg (
    .pclk(pclk),
    .presetn(presetn),
    .bus(avg_bus)
  );

  // Learning sequence: initial level, then final level
  atqpd_learn_t lstate, next_lstate;
  logic [7:0] lcnt, next_lcnt;
  logic [8:0] init_level, final_level, step_val;
  assign init_level = 9'(learn_hi[7:START_LSB]) << LEARN_MULT_SHIFT;
  always_comb begin
    unique case (learn_level_increment)
      2'b00: step_val = STEP_00;
      2'b01: step_val = STEP_01;
      2'b10: step_val = STEP_10;
      default: step_val = STEP_11;
    endcase
  end
  assign final_level = init_level + step_val;
  assign learn_capture = load_torque_count;
  assign learn_done = (lstate == ATQPD_FINAL) && half_cycle && (lcnt == LEARN_HC - 8'h01);
  assign learning = (lstate != ATQPD_IDLE);

  always_comb begin
    next_lstate = lstate;
    next_lcnt = lcnt;
    case (lstate)
      ATQPD_IDLE: begin
        next_lcnt = 8'h00;
        if (learn_trigger) next_lstate = ATQPD_INIT;
      end
      ATQPD_INIT: begin
        if (half_cycle) begin
          next_lcnt = lcnt + 8'h01;
          if (lcnt == LEARN_HC - 8'h01) begin
            next_lcnt = 8'h00;
            next_lstate = ATQPD_FINAL;
          end
        end
      end
      ATQPD_FINAL: begin
        if (half_cycle) next_lcnt = lcnt + 8'h01;
        if (learn_done) next_lstate = ATQPD_IDLE;
      end
      default: next_lstate = ATQPD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lstate <= ATQPD_IDLE;
      lcnt <= 8'h00;
    end else begin
      lstate <= next_lstate;
      lcnt <= next_lcnt;
    end
  end

  // PD loop on the averaged count against the band
  logic [7:0] load8, err, prev_err, next_prev_err, derr, applied, next_applied;
  logic [2:0] hold_cnt, next_hold_cnt;
  logic raise, lower;
  logic [16:0] corr;
  logic [7:0] delta;
  logic [8:0] target;
  assign load8 = load_torque_count[10:BAND_SHIFT];
  assign raise = load8 > band_upper_limit;
  assign lower = load8 < band_lower_limit;
  assign err = raise ? load8 - band_upper_limit : (lower ? band_lower_limit - load8 : 8'h00);
  assign derr = absdiff(err, prev_err);
  assign corr = (17'(proportional_gain) * 17'(err) + 17'(derivative_gain) * 17'(derr)) >> CORR_SHIFT;
  assign delta = (corr > 17'h000ff) ? 8'hff : ((corr == 17'h00000) ? 8'h01 : corr[7:0]);

  always_comb begin
    next_applied = applied;
    next_hold_cnt = hold_cnt;
    next_prev_err = prev_err;
    target = 9'(applied);
    if (!torque_adapt_enable) begin
      next_applied = ceil_reg;
      next_hold_cnt = 3'h0;
      next_prev_err = 8'h00;
    end else if (half_cycle) begin
      if (hold_cnt < hold_eff) next_hold_cnt = hold_cnt + 3'h1;
      // Compare against hold minus one so a move comes every hold half-cycles, counting the moving pulse
      if (hold_cnt >= hold_eff - 3'h1 && (raise || lower)) begin
        if (raise) target = 9'(applied) + 9'(delta);
        else target = (9'(delta) > 9'(applied)) ? 9'h000 : 9'(applied) - 9'(delta);
        next_hold_cnt = 3'h0;
        next_prev_err = err;
      end
    end
    if (torque_adapt_enable) begin
      if (sat8(target) > ceil_reg) next_applied = ceil_reg;
      else if (sat8(target) < floor_reg) next_applied = floor_reg;
      else next_applied = sat8(target);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied <= CEIL_RST;
      hold_cnt <= 3'h0;
      prev_err <= 8'h00;
      coil_current <= CEIL_RST;
    end else begin
      applied <= next_applied;
      hold_cnt <= next_hold_cnt;
      prev_err <= next_prev_err;
      coil_current <= (next_lstate == ATQPD_INIT) ? sat8(init_level) :
                      (next_lstate == ATQPD_FINAL) ? sat8(final_level) : next_applied;
    end
  end

  // Checks
  a_disabled_ceiling: assert property (@(posedge pclk) disable iff (!presetn)
    !torque_adapt_enable && !learning |=> applied == $past(ceil_reg))
    else $error("disabled current not at ceiling");
  a_current_bounds: assert property (@(posedge pclk) disable iff (!presetn)
    torque_adapt_enable && $stable(floor_reg) && $stable(ceil_reg) && floor_reg <= ceil_reg
    |=> applied >= floor_reg && applied <= ceil_reg)
    else $error("current outside floor and ceiling");
  a_change_on_edge: assert property (@(posedge pclk) disable iff (!presetn)
    torque_adapt_enable && $past(torque_adapt_enable) && !half_cycle && $stable(floor_reg) && $stable(ceil_reg)
    |=> $stable(applied))
    else $error("current changed off a half-cycle");
  a_band_hold: assert property (@(posedge pclk) disable iff (!presetn)
    torque_adapt_enable && half_cycle && !raise && !lower && applied >= floor_reg && applied <= ceil_reg
    |=> applied == $past(applied))
    else $error("current moved inside band");
  a_hold_wait: assert property (@(posedge pclk) disable iff (!presetn)
    torque_adapt_enable && half_cycle && hold_cnt < hold_eff - 3'h1 |=> applied == $past(applied))
    else $error("current changed before hold delay");
  a_raise_up: assert property (@(posedge pclk) disable iff (!presetn)
    torque_adapt_enable && half_cycle && raise && hold_cnt >= hold_eff - 3'h1 && applied < ceil_reg
    && floor_reg <= applied |=> applied > $past(applied))
    else $error("current did not rise above band");
  a_learn_start: assert property (@(posedge pclk) disable iff (!presetn)
    lstate == ATQPD_IDLE && learn_trigger |=> lstate == ATQPD_INIT ##0 coil_current == sat8(init_level))
    else $error("learning did not start");
  a_trig_clear: assert property (@(posedge pclk) disable iff (!presetn)
    learn_done && !wr_en |=> !learn_trigger ##1 !learning)
    else $error("trigger not cleared after learning");
  a_apb_err: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");
  c_learn_run: cover property (@(posedge pclk) disable iff (!presetn) learn_done);
  c_raise: cover property (@(posedge pclk) disable iff (!presetn) torque_adapt_enable && half_cycle && raise);
  c_lower: cover property (@(posedge pclk) disable iff (!presetn) torque_adapt_enable && half_cycle && lower);
  c_write_ctrl: cover property (@(posedge pclk) disable iff (!presetn) wr_en && idx == CTRL_IDX);
endmodule : atqpd_top
`default_nettype wire

// ==== verif/atqpd_top_tb.sv ====
// Testbench: register bank, learning, averaging and current loop of the torque block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_total++; $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module atqpd_top_tb;
  import atqpd_pkg::*;
  typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} atqpd_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, half_cycle, learning, er;
  logic [7:0] paddr, coil_current, c0, c1, lo8;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] load_sample;
  int err_total, checks;
  atqpd_row_t rows [7];
  logic [7:0] rst_ex [7];
  logic [2:0] codes [4];
  logic [10:0] avg_ex [4];

  atqpd_top #(.ADDR_W(8), .LEARN_HALF_CYCLES(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .half_cycle(half_cycle), .load_sample(load_sample), .coil_current(coil_current),
    .learning(learning));

  // Free-running 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic close_out;
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // One APB transfer, setup then access until pready
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rdat,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      `CHK("pready", 1'b1, pready)
      close_out();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read one register and compare the low byte, upper bits zero
  task automatic rchk(input logic [7:0] idx, input logic [7:0] ex, input string nm);
    apb(1'b0, idx, 8'h00, rd, er);
    `CHK(nm, {24'h0, ex}, rd)
  endtask : rchk

  // Half-cycle pulses, one cycle high, one low, then settle
  task automatic hc(input int n);
    repeat (n) begin
      @(posedge pclk);
      half_cycle <= 1'b1;
      @(posedge pclk);
      half_cycle <= 1'b0;
    end
    repeat (2) @(posedge pclk);
  endtask : hc

  // Main sequence
  initial begin
    {psel, penable, pwrite, half_cycle} = '0;
    paddr = '0;
    pwdata = '0;
    load_sample = '0;
    presetn = 1'b0;
    err_total = 0;
    checks = 0;
    rows = '{'{LEARN_HI_IDX, 8'hc5, 8'hc5}, '{LEARN_LO_IDX, 8'h33, 8'h33}, '{BAND_UP_IDX, 8'ha5, 8'ha5},
             '{BAND_LO_IDX, 8'h5a, 8'h5a}, '{PGAIN_IDX, 8'h3c, 8'h3c}, '{DGAIN_IDX, 8'hf7, 8'hf7},
             '{CTRL_IDX, 8'h15, 8'h15}};
    rst_ex = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
    codes = '{3'h2, 3'h4, 3'h7, 3'h3};
    avg_ex = '{11'h200, 11'h100, 11'h080, 11'h400};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Ordinary write and read-back rows
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd, rd, er);
      apb(1'b0, rows[i].idx, 8'h00, rd, er);
      `CHK("row readback", {24'h0, rows[i].ex}, rd)
    end
    // Second reset in mid-run, then reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("coil in reset", 8'hff, coil_current)
    presetn <= 1'b1;
    foreach (rows[i]) rchk(rows[i].idx, rst_ex[i], "reset value");
    rchk(CEIL_IDX, 8'hff, "ceiling reset");
    rchk(FLOOR_IDX, 8'h0a, "floor reset");
    rchk(APPLIED_IDX, 8'hff, "applied reset");
    // Disabled: current follows the ceiling
    apb(1'b1, CEIL_IDX, 8'hc0, rd, er);
    repeat (2) @(posedge pclk);
    `CHK("coil off", 8'hc0, coil_current)
    rchk(APPLIED_IDX, 8'hc0, "applied off");
    // Learning at level 5 with step code 10b
    load_sample <= 11'h2b6;
    apb(1'b1, LEARN_HI_IDX, 8'h28, rd, er);
    apb(1'b1, STEP_IDX, 8'h02, rd, er);
    apb(1'b1, CTRL_IDX, 8'h48, rd, er);
    repeat (2) @(posedge pclk);
    `CHK("learn on", 1'b1, learning)
    `CHK("learn initial", 8'h28, coil_current)
    hc(2);
    `CHK("learn final", 8'h48, coil_current)
    hc(2);
    for (int n = 0; learning !== 1'b0; n++) begin
      if (n == 100) begin
        `CHK("learn done", 1'b0, learning)
        close_out();
      end
      @(posedge pclk);
    end
    rchk(CTRL_IDX, 8'h08, "trigger clear");
    rchk(LEARN_HI_IDX, 8'h2a, "learned high");
    rchk(LEARN_LO_IDX, 8'hb6, "learned low");
    rchk(LOAD_LO_IDX, 8'hb6, "load low");
    rchk(LOAD_HI_IDX, 8'h02, "load high");
    // The three averaging window codes and code 3, one step after a run of zeros
    foreach (codes[i]) begin
      apb(1'b1, CTRL_IDX, {5'b00001, codes[i]}, rd, er);
      load_sample <= 11'h000;
      hc(8);
      load_sample <= 11'h400;
      hc(1);
      apb(1'b0, LOAD_LO_IDX, 8'h00, rd, er);
      lo8 = rd[7:0];
      apb(1'b0, LOAD_HI_IDX, 8'h00, rd, er);
      `CHK("average", avg_ex[i], {rd[2:0], lo8})
    end
    // Loop: below band while disabled, then enabled with hold 3
    apb(1'b1, BAND_LO_IDX, 8'h10, rd, er);
    apb(1'b1, BAND_UP_IDX, 8'h20, rd, er);
    apb(1'b1, PGAIN_IDX, 8'h01, rd, er);
    apb(1'b1, DGAIN_IDX, 8'h00, rd, er);
    load_sample <= 11'h078;
    hc(2);
    `CHK("idle when off", 8'hc0, coil_current)
    apb(1'b1, CTRL_IDX, 8'h98, rd, er);
    c0 = coil_current;
    hc(12);
    c1 = coil_current;
    `CHK("held drop", 8'd4, c0 - c1)
    // Inside the band the current holds
    load_sample <= 11'h0c0;
    hc(1);
    c0 = coil_current;
    hc(6);
    `CHK("band hold", c0, coil_current)
    // Far above the band: rise clamped at the ceiling
    load_sample <= 11'h7f8;
    hc(12);
    `CHK("rise clamp", 8'hc0, coil_current)
    apb(1'b1, CTRL_IDX, 8'h18, rd, er);
    apb(1'b1, CEIL_IDX, 8'hb0, rd, er);
    repeat (2) @(posedge pclk);
    `CHK("off ceiling", 8'hb0, coil_current)
    // Hold seven: count saturates in band, then the first pulse out of band moves
    apb(1'b1, FLOOR_IDX, 8'ha8, rd, er);
    load_sample <= 11'h0c0;
    apb(1'b1, CTRL_IDX, 8'hb8, rd, er);
    hc(8);
    load_sample <= 11'h078;
    hc(2);
    `CHK("hold seven", 8'haf, coil_current)
    // Hold one: a drop every half-cycle, stopped at the floor
    apb(1'b1, CTRL_IDX, 8'h88, rd, er);
    hc(12);
    `CHK("floor clamp", 8'ha8, coil_current)
    // Unmapped place: error, write dropped, read zero
    apb(1'b1, 8'h3f, 8'hff, rd, er);
    `CHK("error on write", 1'b1, er)
    apb(1'b0, 8'h3f, 8'h00, rd, er);
    `CHK("error on read", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    close_out();
  end
endmodule : atqpd_top_tb
`default_nettype wire
